//--- hw/fcfg_pkg.sv
package fcfg_pkg;

    // register word and address widths
    localparam int DATA_W = 16;
    localparam int ADDR_W_DEF = 5;
    localparam int ADDR_W_MIN = 4;
    localparam int ADDR_W_MAX = 8;

    // register offsets
    localparam logic [7:0] REG_CH4_HI = 8'h0A;
    localparam logic [7:0] REG_CH4_LO = 8'h0B;
    localparam logic [7:0] REG_CH5_CTRL = 8'h0C;
    localparam logic [7:0] REG_CH5_HI = 8'h0D;
    localparam logic [7:0] REG_CH5_LO = 8'h0E;

    // reset value of every register
    localparam logic [15:0] REG_RESET = 16'h0000;

    // writable bits; reserved bits are dropped and read as zero
    localparam logic [15:0] DIV_HI_MASK = 16'h0FFF;
    localparam logic [15:0] DIV_LO_MASK = 16'hFFFF;
    localparam logic [15:0] CTRL_MASK = 16'h7FDF;

    // divider word layout
    localparam int INT_W = 8;
    localparam int RATIO_W = 9;
    localparam int FRAC_W = 20;
    localparam int INT_LSB = 4;
    localparam int INT_MSB = 11;
    localparam int FRAC_TOP_MSB = 3;
    localparam logic [8:0] RATIO_STEP = 9'h001;

    // control register layout
    localparam int SRC_MSB = 14;
    localparam int SRC_LSB = 13;
    localparam int PRE_MSB = 12;
    localparam int PRE_LSB = 10;
    localparam int FRAC_EN_BIT = 9;
    localparam int SLEW_BIT = 8;
    localparam int NEG_BIT = 7;
    localparam int POS_BIT = 6;
    localparam int DRV_MSB = 4;
    localparam int DRV_LSB = 3;
    localparam int OUT_MSB = 2;
    localparam int OUT_LSB = 1;
    localparam int SUPPLY_BIT = 0;

    // source select codes
    localparam logic [1:0] SRC_SYNTH_A = 2'h0;
    localparam logic [1:0] SRC_PRIMARY = 2'h1;
    localparam logic [1:0] SRC_SECONDARY = 2'h2;
    localparam logic [1:0] SRC_SYNTH_B = 2'h3;

    // prescale codes and the divisor reported for them
    localparam logic [2:0] PRE_DIV2 = 3'h0;
    localparam logic [2:0] PRE_DIV3 = 3'h1;
    localparam logic [2:0] PRE_DIV1 = 3'h7;
    localparam logic [1:0] DIVISOR_NONE = 2'h0;
    localparam logic [1:0] DIVISOR_1 = 2'h1;
    localparam logic [1:0] DIVISOR_2 = 2'h2;
    localparam logic [1:0] DIVISOR_3 = 2'h3;

    // driver kind codes
    localparam logic [1:0] DRV_LVDS_A = 2'h0;
    localparam logic [1:0] DRV_LVDS_B = 2'h1;
    localparam logic [1:0] DRV_LVCMOS = 2'h2;
    localparam logic [1:0] DRV_HCSL = 2'h3;

    // output state codes
    localparam logic [1:0] OUT_OFF = 2'h0;
    localparam logic [1:0] OUT_RUN = 2'h1;
    localparam logic [1:0] OUT_LOW = 2'h2;
    localparam logic [1:0] OUT_HIGH = 2'h3;

endpackage

//--- hw/fcfg_div_if.sv
`timescale 1ns/100ps
interface fcfg_div_if;
    import fcfg_pkg::*;
    logic [DATA_W-1:0] hiWord;
    logic [DATA_W-1:0] loWord;
    logic [RATIO_W-1:0] ratio;
    logic [FRAC_W-1:0] fraction;

    modport feeder (output hiWord, output loWord, input ratio, input fraction);
    modport decoder (input hiWord, input loWord, output ratio, output fraction);
endinterface

//--- hw/fcfg_div_word.sv
`timescale 1ns/100ps
module fcfg_div_word (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // register words in, divider settings out
    fcfg_div_if.decoder div
);
    import fcfg_pkg::*;

    typedef struct packed {
        logic [RATIO_W-1:0] ratio;
        logic [FRAC_W-1:0] fraction;
    } fcfg_div_s;

    fcfg_div_s state_q;
    fcfg_div_s state_d;

    always_comb begin
        state_d = state_q;
        // applied ratio is the stored field plus one
        state_d.ratio = RATIO_W'(div.hiWord[INT_MSB:INT_LSB]) + RATIO_STEP;
        // top four fraction bits ride in the integer register
        state_d.fraction = {div.hiWord[FRAC_TOP_MSB:0], div.loWord};
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign div.ratio = state_q.ratio;
    assign div.fraction = state_q.fraction;
endmodule

//--- hw/fcfg_frac_output_regs.sv
`timescale 1ns/100ps
module fcfg_frac_output_regs #(
    parameter int ADDR_W = fcfg_pkg::ADDR_W_DEF
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // register access from the serial configuration port
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [fcfg_pkg::DATA_W-1:0] regWrData,
    output logic [fcfg_pkg::DATA_W-1:0] regRdData,
    output logic regRdValid,
    output logic regRdMiss,
    // channel four divider
    output logic [fcfg_pkg::RATIO_W-1:0] ch4IntegerRatio,
    output logic [fcfg_pkg::FRAC_W-1:0] ch4FractionWord,
    // channel five divider
    output logic [fcfg_pkg::RATIO_W-1:0] ch5IntegerRatio,
    output logic [fcfg_pkg::FRAC_W-1:0] ch5FractionWord,
    // channel five source
    output logic ch5SrcSynth,
    output logic ch5SrcPrimary,
    output logic ch5SrcSecondary,
    // channel five prescaler and fraction enable
    output logic [1:0] ch5PrescaleDivisor,
    output logic ch5PrescaleReserved,
    output logic ch5FractionEnable,
    // channel five driver
    output logic ch5EdgeRateSlow,
    output logic ch5PositiveSideOn,
    output logic ch5NegativeSideOn,
    output logic ch5DrvLvds,
    output logic ch5DrvLvcmos,
    output logic ch5DrvHcsl,
    // channel five output state and supply
    output logic ch5OutRunning,
    output logic ch5OutStatic,
    output logic ch5StaticLevel,
    output logic ch5SupplyHigh
);
    import fcfg_pkg::*;

    // too narrow and the top offset aliases onto a lower one
    if (ADDR_W < ADDR_W_MIN || ADDR_W > ADDR_W_MAX) begin : g_addr_w_check
        $error("fcfg_frac_output_regs: ADDR_W out of range");
    end

    ////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        logic [DATA_W-1:0] ch4Hi;
        logic [DATA_W-1:0] ch4Lo;
        logic [DATA_W-1:0] ch5Ctrl;
        logic [DATA_W-1:0] ch5Hi;
        logic [DATA_W-1:0] ch5Lo;
        logic [DATA_W-1:0] rdData;
        logic rdValid;
        logic rdMiss;
        logic srcSynth;
        logic srcPrimary;
        logic srcSecondary;
        logic [1:0] preDivisor;
        logic preReserved;
        logic fracEnable;
        logic slewSlow;
        logic posOn;
        logic negOn;
        logic drvLvds;
        logic drvLvcmos;
        logic drvHcsl;
        logic outRunning;
        logic outStatic;
        logic staticLevel;
        logic supplyHigh;
    } fcfg_top_s;

    fcfg_top_s state_q;
    fcfg_top_s state_d;

    // one-hot views of the source and driver codes; flag view of the output state code
    typedef struct packed {
        logic synth;
        logic primary;
        logic secondary;
    } fcfg_src_s;

    typedef struct packed {
        logic lvds;
        logic lvcmos;
        logic hcsl;
    } fcfg_drv_s;

    typedef struct packed {
        logic running;
        logic isStatic;
        logic level;
    } fcfg_out_s;

    // both end codes pick the synthesizer, so no code leaves the mux open
    function automatic fcfg_src_s srcDecode(input logic [1:0] code);
        fcfg_src_s s;
        s.synth = (code == SRC_SYNTH_A) || (code == SRC_SYNTH_B);
        s.primary = code == SRC_PRIMARY;
        s.secondary = code == SRC_SECONDARY;
        return s;
    endfunction

    // both low codes select the low-swing differential driver
    function automatic fcfg_drv_s drvDecode(input logic [1:0] code);
        fcfg_drv_s k;
        k.lvds = (code == DRV_LVDS_A) || (code == DRV_LVDS_B);
        k.lvcmos = code == DRV_LVCMOS;
        k.hcsl = code == DRV_HCSL;
        return k;
    endfunction

    function automatic fcfg_out_s outDecode(input logic [1:0] code);
        fcfg_out_s o;
        o.running = code == OUT_RUN;
        o.isStatic = (code == OUT_LOW) || (code == OUT_HIGH);
        o.level = code == OUT_HIGH;
        return o;
    endfunction

    // address match against a register offset
    function automatic logic addrHit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        return a == ADDR_W'(off);
    endfunction

    // prescale code to divisor; reserved codes report no divisor
    function automatic logic [1:0] preDecode(input logic [2:0] code);
        logic [1:0] d;
        d = DIVISOR_NONE;
        unique case (code)
            PRE_DIV2: d = DIVISOR_2;
            PRE_DIV3: d = DIVISOR_3;
            PRE_DIV1: d = DIVISOR_1;
            default: d = DIVISOR_NONE;
        endcase
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////////////

    fcfg_div_if divIf[2] ();

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_div
            fcfg_div_word u_div (
                .sys_clk(sys_clk),
                .rst_n(rst_n),
                .div(divIf[gi].decoder)
            );
        end
    endgenerate

    assign divIf[0].hiWord = state_q.ch4Hi;
    assign divIf[0].loWord = state_q.ch4Lo;
    assign divIf[1].hiWord = state_q.ch5Hi;
    assign divIf[1].loWord = state_q.ch5Lo;

    ////////////////////////////////////////////////////////////////////////////

    logic hitCh4Hi;
    logic hitCh4Lo;
    logic hitCtrl;
    logic hitCh5Hi;
    logic hitCh5Lo;
    logic anyHit;
    logic [2:0] preCode;
    fcfg_src_s srcHot;
    fcfg_drv_s drvHot;
    fcfg_out_s outHot;

    always_comb begin
        state_d = state_q;
        // one compare per register, shared by the write and the read path
        hitCh4Hi = addrHit(regAddr, REG_CH4_HI);
        hitCh4Lo = addrHit(regAddr, REG_CH4_LO);
        hitCtrl = addrHit(regAddr, REG_CH5_CTRL);
        hitCh5Hi = addrHit(regAddr, REG_CH5_HI);
        hitCh5Lo = addrHit(regAddr, REG_CH5_LO);
        anyHit = hitCh4Hi || hitCh4Lo || hitCtrl || hitCh5Hi || hitCh5Lo;
        preCode = state_q.ch5Ctrl[PRE_MSB:PRE_LSB];
        srcHot = srcDecode(state_q.ch5Ctrl[SRC_MSB:SRC_LSB]);
        drvHot = drvDecode(state_q.ch5Ctrl[DRV_MSB:DRV_LSB]);
        outHot = outDecode(state_q.ch5Ctrl[OUT_MSB:OUT_LSB]);

        // writes; reserved bits never stored, so a stray one cannot reach the dividers
        if (regWrEn) begin
            if (hitCh4Hi) begin
                state_d.ch4Hi = regWrData & DIV_HI_MASK;
            end
            if (hitCh4Lo) begin
                state_d.ch4Lo = regWrData & DIV_LO_MASK;
            end
            if (hitCtrl) begin
                state_d.ch5Ctrl = regWrData & CTRL_MASK;
            end
            if (hitCh5Hi) begin
                state_d.ch5Hi = regWrData & DIV_HI_MASK;
            end
            if (hitCh5Lo) begin
                state_d.ch5Lo = regWrData & DIV_LO_MASK;
            end
        end

        // reads return the value held before any write in the same cycle
        state_d.rdValid = regRdEn;
        state_d.rdMiss = regRdEn && !anyHit;
        state_d.rdData = REG_RESET;
        if (regRdEn) begin
            if (hitCh4Hi) begin
                state_d.rdData = state_q.ch4Hi;
            end
            if (hitCh4Lo) begin
                state_d.rdData = state_q.ch4Lo;
            end
            if (hitCtrl) begin
                state_d.rdData = state_q.ch5Ctrl;
            end
            if (hitCh5Hi) begin
                state_d.rdData = state_q.ch5Hi;
            end
            if (hitCh5Lo) begin
                state_d.rdData = state_q.ch5Lo;
            end
        end

        // channel five control decode
        state_d.srcSynth = srcHot.synth;
        state_d.srcPrimary = srcHot.primary;
        state_d.srcSecondary = srcHot.secondary;

        state_d.fracEnable = state_q.ch5Ctrl[FRAC_EN_BIT];
        if (state_q.ch5Ctrl[FRAC_EN_BIT]) begin
            state_d.preDivisor = preDecode(preCode);
            state_d.preReserved = preDecode(preCode) == DIVISOR_NONE;
        end else begin
            state_d.preDivisor = DIVISOR_1;
            state_d.preReserved = 1'b0;
        end

        state_d.slewSlow = state_q.ch5Ctrl[SLEW_BIT];
        state_d.posOn = state_q.ch5Ctrl[POS_BIT];
        // a lone negative enable stays off rather than drive one leg
        state_d.negOn = state_q.ch5Ctrl[NEG_BIT] && state_q.ch5Ctrl[POS_BIT];

        state_d.drvLvds = drvHot.lvds;
        state_d.drvLvcmos = drvHot.lvcmos;
        state_d.drvHcsl = drvHot.hcsl;

        state_d.outRunning = outHot.running;
        state_d.outStatic = outHot.isStatic;
        state_d.staticLevel = outHot.level;

        // registered from the stored bit, so a late correction takes effect one clock after the register updates
        state_d.supplyHigh = state_q.ch5Ctrl[SUPPLY_BIT];
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    assign regRdData = state_q.rdData;
    assign regRdValid = state_q.rdValid;
    assign regRdMiss = state_q.rdMiss;
    assign ch4IntegerRatio = divIf[0].ratio;
    assign ch4FractionWord = divIf[0].fraction;
    assign ch5IntegerRatio = divIf[1].ratio;
    assign ch5FractionWord = divIf[1].fraction;
    assign ch5SrcSynth = state_q.srcSynth;
    assign ch5SrcPrimary = state_q.srcPrimary;
    assign ch5SrcSecondary = state_q.srcSecondary;
    assign ch5PrescaleDivisor = state_q.preDivisor;
    assign ch5PrescaleReserved = state_q.preReserved;
    assign ch5FractionEnable = state_q.fracEnable;
    assign ch5EdgeRateSlow = state_q.slewSlow;
    assign ch5PositiveSideOn = state_q.posOn;
    assign ch5NegativeSideOn = state_q.negOn;
    assign ch5DrvLvds = state_q.drvLvds;
    assign ch5DrvLvcmos = state_q.drvLvcmos;
    assign ch5DrvHcsl = state_q.drvHcsl;
    assign ch5OutRunning = state_q.outRunning;
    assign ch5OutStatic = state_q.outStatic;
    assign ch5StaticLevel = state_q.staticLevel;
    assign ch5SupplyHigh = state_q.supplyHigh;
endmodule

//--- dv/fcfg_host_model.sv
`timescale 1ns/100ps
module fcfg_host_model #(
    parameter int ADDR_W = fcfg_pkg::ADDR_W_DEF
) (
    // clock
    input wire logic sys_clk,
    // requests
    output logic regWrEn,
    output logic regRdEn,
    output logic [ADDR_W-1:0] regAddr,
    output logic [fcfg_pkg::DATA_W-1:0] regWrData,
    // answers
    input wire logic [fcfg_pkg::DATA_W-1:0] regRdData,
    input wire logic regRdValid,
    input wire logic regRdMiss
);
    import fcfg_pkg::*;
    initial begin
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = '0;
        regWrData = '0;
    end
    ////////////////////////////////////////////////////////////////
    // released lines show the inverse so a stale word never looks fresh
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(negedge sys_clk);
        regWrEn = 1'b1;
        regAddr = a;
        regWrData = d;
        @(negedge sys_clk);
        regWrEn = 1'b0;
        regAddr = ~a;
        regWrData = ~d;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic m, output bit ok);
        int k;
        ok = 1'b0;
        d = '0;
        m = 1'b0;
        @(negedge sys_clk);
        regRdEn = 1'b1;
        regAddr = a;
        for (k = 0; k < 4 && !ok; k++) begin
            @(negedge sys_clk);
            if (regRdValid === 1'b1) begin
                ok = 1'b1;
                d = regRdData;
                m = regRdMiss;
            end
        end
        regRdEn = 1'b0;
        regAddr = ~a;
    endtask
endmodule

//--- dv/fcfg_regs_checker.sv
`timescale 1ns/100ps
module fcfg_regs_checker #(
    parameter int ADDR_W = fcfg_pkg::ADDR_W_DEF
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // register port
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [fcfg_pkg::DATA_W-1:0] regWrData,
    input wire logic [fcfg_pkg::DATA_W-1:0] regRdData,
    input wire logic regRdValid,
    input wire logic regRdMiss,
    // decoded settings
    input wire logic [fcfg_pkg::RATIO_W-1:0] ch4IntegerRatio,
    input wire logic [fcfg_pkg::FRAC_W-1:0] ch4FractionWord,
    input wire logic [fcfg_pkg::FRAC_W-1:0] ch5FractionWord,
    input wire logic [1:0] ch5PrescaleDivisor,
    input wire logic ch5FractionEnable,
    input wire logic ch5PositiveSideOn,
    input wire logic ch5NegativeSideOn,
    input wire logic ch5DrvHcsl,
    input wire logic ch5OutStatic,
    input wire logic ch5SrcPrimary,
    input wire logic ch5SupplyHigh
);
    import fcfg_pkg::*;
    logic wHi4, wLo4, wLo5, wCtl, mapped;
    assign wHi4 = regWrEn && regAddr == ADDR_W'(REG_CH4_HI);
    assign wLo4 = regWrEn && regAddr == ADDR_W'(REG_CH4_LO);
    assign wLo5 = regWrEn && regAddr == ADDR_W'(REG_CH5_LO);
    assign wCtl = regWrEn && regAddr == ADDR_W'(REG_CH5_CTRL);
    assign mapped = regAddr >= ADDR_W'(REG_CH4_HI) && regAddr <= ADDR_W'(REG_CH5_LO);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////
    // decoded outputs lag the register by one edge
    sequence s_settled(w);
        w ##2 1'b1;
    endsequence
    sequence s_answer;
        regRdEn ##1 regRdValid;
    endsequence
    a_read_answer: assert property (regRdEn |-> s_answer) else $error("read not answered");
    a_miss_flag: assert property (regRdEn |=> regRdMiss == !$past(mapped)) else $error("miss flag wrong");
    a_valid_cause: assert property (regRdValid |-> $past(regRdEn)) else $error("valid without read");
    a_data_idle: assert property (!regRdValid |-> regRdData == '0) else $error("data outside valid");
    a_ratio_plus: assert property (s_settled(wHi4) |->
        ch4IntegerRatio == {1'b0, $past(regWrData[INT_MSB:INT_LSB], 2)} + RATIO_STEP
        && ch4FractionWord[19:16] == $past(regWrData[FRAC_TOP_MSB:0], 2)) else $error("ratio wrong");
    a_frac_low4: assert property (s_settled(wLo4) |-> ch4FractionWord[15:0] == $past(regWrData, 2))
        else $error("ch4 fraction wrong");
    a_frac_low5: assert property (s_settled(wLo5) |-> ch5FractionWord[15:0] == $past(regWrData, 2))
        else $error("ch5 fraction wrong");
    a_ctrl_fields: assert property (s_settled(wCtl) |->
        ch5SrcPrimary == ($past(regWrData[SRC_MSB:SRC_LSB], 2) == SRC_PRIMARY)
        && ch5DrvHcsl == ($past(regWrData[DRV_MSB:DRV_LSB], 2) == DRV_HCSL)
        && ch5OutStatic == $past(regWrData[OUT_MSB], 2)
        && ch5SupplyHigh == $past(regWrData[SUPPLY_BIT], 2)) else $error("control decode wrong");
    a_neg_gated: assert property (ch5NegativeSideOn |-> ch5PositiveSideOn) else $error("negative alone");
    a_bypass_unity: assert property ($past(rst_n) && !ch5FractionEnable |-> ch5PrescaleDivisor == DIVISOR_1)
        else $error("prescaler not bypassed");
endmodule
bind fcfg_frac_output_regs fcfg_regs_checker #(.ADDR_W(ADDR_W)) chk (.sys_clk, .rst_n, .regWrEn, .regRdEn,
    .regAddr, .regWrData, .regRdData, .regRdValid, .regRdMiss, .ch4IntegerRatio, .ch4FractionWord,
    .ch5FractionWord, .ch5PrescaleDivisor, .ch5FractionEnable, .ch5PositiveSideOn, .ch5NegativeSideOn,
    .ch5DrvHcsl, .ch5OutStatic, .ch5SrcPrimary, .ch5SupplyHigh);

//--- dv/fcfg_testbench.sv
`timescale 1ns/100ps
module testbench;
    import fcfg_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic regWrEn, regRdEn, regRdValid, regRdMiss;
    logic [4:0] regAddr;
    logic [15:0] regWrData, regRdData;
    logic [8:0] ch4IntegerRatio, ch5IntegerRatio;
    logic [19:0] ch4FractionWord, ch5FractionWord;
    logic [1:0] ch5PrescaleDivisor;
    logic ch5SrcSynth, ch5SrcPrimary, ch5SrcSecondary, ch5PrescaleReserved, ch5FractionEnable;
    logic ch5EdgeRateSlow, ch5PositiveSideOn, ch5NegativeSideOn, ch5DrvLvds, ch5DrvLvcmos, ch5DrvHcsl;
    logic ch5OutRunning, ch5OutStatic, ch5StaticLevel, ch5SupplyHigh;
    int mismatches = 0;
    int samples_checked = 0;
    int m [5];
    localparam int MASK [5] = '{DIV_HI_MASK, DIV_LO_MASK, CTRL_MASK, DIV_HI_MASK, DIV_LO_MASK};
    fcfg_frac_output_regs uut (.sys_clk, .rst_n, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData,
        .regRdValid, .regRdMiss, .ch4IntegerRatio, .ch4FractionWord, .ch5IntegerRatio, .ch5FractionWord,
        .ch5SrcSynth, .ch5SrcPrimary, .ch5SrcSecondary, .ch5PrescaleDivisor, .ch5PrescaleReserved,
        .ch5FractionEnable, .ch5EdgeRateSlow, .ch5PositiveSideOn, .ch5NegativeSideOn, .ch5DrvLvds,
        .ch5DrvLvcmos, .ch5DrvHcsl, .ch5OutRunning, .ch5OutStatic, .ch5StaticLevel, .ch5SupplyHigh);
    fcfg_host_model host (.sys_clk, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData, .regRdValid,
        .regRdMiss);
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrM(input logic [4:0] a, input logic [15:0] d);
        int i;
        i = int'(a) - 10;
        host.wr(a, d);
        if (i >= 0 && i < 5) begin
            m[i] = d & MASK[i];
        end
    endtask
    task automatic rdChk(input logic [4:0] a);
        logic [15:0] d;
        logic ms;
        bit ok;
        int i;
        i = int'(a) - 10;
        host.rd(a, d, ms, ok);
        if (!ok) begin
            mismatches++;
            results();
        end else begin
            cmp(d, (i >= 0 && i < 5) ? m[i] : 0);
            cmp(ms, !(i >= 0 && i < 5));
        end
    endtask
    task automatic outChk();
        int c, s, p, dv, st, dsr;
        c = m[2];
        s = c[14:13];
        p = c[12:10];
        dv = c[4:3];
        st = c[2:1];
        dsr = !c[9] ? 1 : p == 0 ? 2 : p == 1 ? 3 : p == 7 ? 1 : 0;
        cmp(ch4IntegerRatio, m[0][11:4] + 1);
        cmp(ch4FractionWord, {m[0][3:0], m[1][15:0]});
        cmp({ch5IntegerRatio, ch5FractionWord}, {m[3][11:4] + 9'h001, m[3][3:0], m[4][15:0]});
        cmp({ch5SrcSynth, ch5SrcPrimary, ch5SrcSecondary}, {s == 0 || s == 3, s == 1, s == 2});
        cmp({ch5PrescaleDivisor, ch5PrescaleReserved}, {dsr[1:0], c[9] && dsr == 0});
        cmp(ch5FractionEnable, c[9]);
        cmp(ch5EdgeRateSlow, c[8]);
        cmp({ch5PositiveSideOn, ch5NegativeSideOn}, {c[6], c[7] & c[6]});
        cmp({ch5DrvLvds, ch5DrvLvcmos, ch5DrvHcsl}, {dv < 2, dv == 2, dv == 3});
        cmp({ch5OutRunning, ch5OutStatic, ch5StaticLevel}, {st == 1, st[1], st == 3});
        cmp(ch5SupplyHigh, c[0]);
    endtask
    task automatic doReset();
        int i;
        rst_n = 1'b0;
        for (i = 0; i < 5; i++) begin
            m[i] = 0;
        end
        repeat (6) @(negedge sys_clk);
        rst_n = 1'b1;
        for (i = 0; i < 6; i++) begin
            rdChk(5'h0A + 5'(i));
        end
        outChk();
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        int n, k;
        logic [15:0] d, c;
        void'($urandom(22));
        doReset();
        // supply bit left clear after power-up, then raised by a later write
        wrM(5'h0C, 16'h0000);
        rdChk(5'h0C);
        outChk();
        wrM(5'h0C, 16'h0001);
        rdChk(5'h0C);
        outChk();
        for (n = 0; n < 64; n++) begin
            c = 16'($urandom);
            c[14:10] = 5'(n);
            c[4:1] = 4'(n);
            c[9] = n[5];
            // only a few words break the side-enable pairing on purpose
            if (n[1:0] != 2'h3) begin
                c[7] = c[7] & c[6];
            end
            if (n[2]) begin
                c = c & CTRL_MASK;
            end
            k = $urandom_range(3, 0);
            k = k >= 2 ? k + 1 : k;
            d = 16'($urandom);
            wrM(5'h0C, c);
            wrM(5'h0A + 5'(k), d);
            wrM(n[0] ? 5'h1F : 5'h09, ~d);
            rdChk(5'h0C);
            rdChk(5'h0A + 5'(k));
            outChk();
        end
        rdChk(5'h09);
        doReset();
        results();
    end
    initial begin
        #250000;
        mismatches++;
        results();
    end
endmodule
